/* File: common/acr_cfg.svh */
// Register offsets, writable masks, reset values for channel trim bank
`ifndef ACR_CFG_SVH
`define ACR_CFG_SVH
// Register indices; byte address is four times the index
`define ACR_IDX_CH0_GAIN_LO   6'h0D
`define ACR_IDX_DC_BLOCK      6'h08
`define ACR_IDX_CH1_CONFIG    6'h0E
`define ACR_IDX_CH1_OFS_HI    6'h0F
`define ACR_IDX_CH1_OFS_LO    6'h10
`define ACR_IDX_CH1_GAIN_HI   6'h11
`define ACR_IDX_CH1_GAIN_LO   6'h12
`define ACR_IDX_CH2_CONFIG    6'h13
// Reset values
`define ACR_RST_ZERO          16'h0000
`define ACR_RST_GAIN_HI       16'h8000
// Writable bit masks
`define ACR_MASK_CONFIG       16'hFFC7
`define ACR_MASK_TRIM_LO      16'hFF00
`define ACR_MASK_DC_BLOCK     16'h000F
`define ACR_MASK_FULL         16'hFFFF
// Unmapped read value
`define ACR_RD_UNMAPPED       32'h0000_0000
`endif

/* File: common/acr_pkg.sv */
// Types for the channel configuration and calibration register bank
package acr_pkg;

  // Converter input selection
  typedef enum logic [1:0] {
    ACR_IN_PINS     = 2'h0,
    ACR_IN_SHORTED  = 2'h1,
    ACR_IN_DIAG_POS = 2'h2,
    ACR_IN_DIAG_NEG = 2'h3
  } acr_input_sel_t;

  // Decoded settings of one channel
  typedef struct packed {
    logic [9:0]     phase_delay;
    logic           dc_block_bypass;
    logic [3:0]     dc_block_setting;
    acr_input_sel_t input_select;
    logic [23:0]    offset_trim;
    logic [23:0]    gain_trim;
  } acr_chan_ctrl_t;

  // Bus response states
  typedef enum logic [1:0] {
    ACR_ST_IDLE = 2'h0,
    ACR_ST_ACK  = 2'h1
  } acr_state_t;

endpackage

/* File: rtl/acr_reg_word.sv */
`timescale 1ns/1ps
// One 16-bit register word with a writable mask and a reset value
module acr_reg_word #(
  parameter logic [15:0] RESET_VAL = 16'h0000,
  parameter logic [15:0] WR_MASK   = 16'hFFFF
) (
  input  wire logic        clk,    // System clock
  input  wire logic        rst,    // Synchronous reset
  input  wire logic        wr_en,  // Write strobe
  input  wire logic [15:0] wr_data, // Write data
  input  wire logic [1:0]  wr_be,  // Byte enables
  output logic      [15:0] val_q   // Stored value
);
  logic [15:0] val_d;
  logic [15:0] lane_mask;

  // Mask of bits the write may change
  always_comb begin
    lane_mask = {{8{wr_be[1]}}, {8{wr_be[0]}}} & WR_MASK;
    val_d     = val_q;
    if (wr_en) begin
      val_d = (val_q & ~lane_mask) | (wr_data & lane_mask);
    end
  end

  // Reserved bits never leave their reset value of zero
  always_ff @(posedge clk) begin
    if (rst) begin
      val_q <= RESET_VAL;
    end else begin
      val_q <= val_d;
    end
  end
endmodule

/* File: rtl/acr_regs.sv */
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps
// Channel configuration and calibration register bank on Avalon-MM
// Functional notes
// R1 - Config bits 15:6 hold a read/write phase delay, reset zero.
// R2 - Config bit 2 bypasses dc-block for that channel; zero follows global.
// R3 - Input select 00 picks pin pair, 01 shorts converter inputs.
// R4 - Input select 10 gives positive, 11 negative dc diagnostic signal.
// R5 - Offset high register holds offset bits 23:8, read/write, reset zero.
// R6 - Offset low register upper byte holds bits 7:0; low byte reserved.
// R7 - Gain high register holds gain bits 23:8, resets to 8000h.
// R8 - Gain low upper byte holds gain bits 7:0; low byte reserved.
// R9 - Global dc-block setting is four read/write bits 3:0.
// R10 - Reserved bits read zero; writes to them are ignored.
// R11 - Calibration word is high register above low register upper byte.
`include "acr_cfg.svh"
module acr_regs (
  input  wire logic                 clk,            // 10 MHz clock
  input  wire logic                 rst,            // Sync reset, active high
  input  wire logic [7:0]           avs_address,    // Byte address
  input  wire logic                 avs_read,       // Read request
  input  wire logic                 avs_write,      // Write request
  input  wire logic [31:0]          avs_writedata,  // Write data
  input  wire logic [3:0]           avs_byteenable, // Byte enables
  output logic      [31:0]          avs_readdata,   // Read data
  output logic                      avs_waitrequest, // Stall
  output acr_pkg::acr_chan_ctrl_t   chan1_ctrl,     // Channel 1 settings
  output acr_pkg::acr_chan_ctrl_t   chan2_ctrl,     // Channel 2 settings
  output logic      [7:0]           chan0_gain_trim_lower // Ch0 gain bits
);
  import acr_pkg::*;

  localparam int NREG = 8;

  // All state of the bus side
  typedef struct packed {
    acr_state_t  state;
    logic [31:0] rdata;
  } acr_bus_state_t;

  acr_bus_state_t st_q;
  acr_bus_state_t st_d;

  logic [15:0]       reg_val [NREG];
  logic [NREG-1:0]   reg_hit;
  logic              access;
  logic              wr_fire;
  logic [5:0]        idx;
  logic              aligned;

  // Register word index for each slot
  function automatic logic [5:0] slot_idx(input int s);
    case (s)
      0:       slot_idx = `ACR_IDX_DC_BLOCK;
      1:       slot_idx = `ACR_IDX_CH0_GAIN_LO;
      2:       slot_idx = `ACR_IDX_CH1_CONFIG;
      3:       slot_idx = `ACR_IDX_CH1_OFS_HI;
      4:       slot_idx = `ACR_IDX_CH1_OFS_LO;
      5:       slot_idx = `ACR_IDX_CH1_GAIN_HI;
      6:       slot_idx = `ACR_IDX_CH1_GAIN_LO;
      default: slot_idx = `ACR_IDX_CH2_CONFIG;
    endcase
  endfunction

  // Writable mask per slot; reserved bits stay zero
  function automatic logic [15:0] slot_mask(input int s);
    case (s)
      0:       slot_mask = `ACR_MASK_DC_BLOCK; // R9 R10
      1:       slot_mask = `ACR_MASK_TRIM_LO;  // R8 R10
      2:       slot_mask = `ACR_MASK_CONFIG;   // R1 R2 R3 R10
      3:       slot_mask = `ACR_MASK_FULL;     // R5
      4:       slot_mask = `ACR_MASK_TRIM_LO;  // R6 R10
      5:       slot_mask = `ACR_MASK_FULL;     // R7
      6:       slot_mask = `ACR_MASK_TRIM_LO;  // R8 R10
      default: slot_mask = `ACR_MASK_CONFIG;   // R1 R10
    endcase
  endfunction

  assign idx     = avs_address[7:2];
  assign aligned = (avs_address[1:0] == 2'h0);
  assign access  = (avs_read | avs_write) && (st_q.state == ACR_ST_IDLE);
  assign wr_fire = avs_write && (st_q.state == ACR_ST_IDLE);

  // One storage word per register
  generate
    for (genvar g = 0; g < NREG; g++) begin : g_word
      localparam logic [15:0] RV = (g == 5) ? `ACR_RST_GAIN_HI
                                            : `ACR_RST_ZERO; // R7
      assign reg_hit[g] = aligned && (idx == slot_idx(g));
      acr_reg_word #(
        .RESET_VAL (RV),
        .WR_MASK   (slot_mask(g))
      ) u_word (
        .clk     (clk),
        .rst     (rst),
        .wr_en   (wr_fire && reg_hit[g]),
        .wr_data (avs_writedata[15:0]),
        .wr_be   (avs_byteenable[1:0]),
        .val_q   (reg_val[g])
      );
    end
  endgenerate

  // Bus sequencing and read mux; unmapped reads return zero
  always_comb begin
    st_d = st_q;
    case (st_q.state)
      ACR_ST_IDLE: begin
        if (access) begin
          st_d.state = ACR_ST_ACK;
          st_d.rdata = `ACR_RD_UNMAPPED;
          for (int s = 0; s < NREG; s++) begin
            if (reg_hit[s]) begin
              st_d.rdata = {16'h0000, reg_val[s]}; // R10
            end
          end
        end
      end
      ACR_ST_ACK: begin
        st_d.state = ACR_ST_IDLE;
      end
      default: begin
        st_d.state = ACR_ST_IDLE;
      end
    endcase
  end

  // Registered bus state
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '{state: ACR_ST_IDLE, rdata: 32'h0000_0000};
    end else begin
      st_q <= st_d;
    end
  end

  // Waitrequest high only in the first cycle of an access, so every access takes two
  assign avs_waitrequest = (avs_read | avs_write) &&
                           (st_q.state != ACR_ST_ACK);
  assign avs_readdata    = st_q.rdata;

  // Settings handed to each channel's data path
  always_comb begin
    chan1_ctrl.phase_delay      = reg_val[2][15:6];          // R1
    chan1_ctrl.dc_block_bypass  = reg_val[2][2];             // R2
    chan1_ctrl.dc_block_setting = reg_val[2][2] ? 4'h0
                                  : reg_val[0][3:0];         // R2 R9
    chan1_ctrl.input_select     = acr_input_sel_t'(reg_val[2][1:0]); // R3 R4
    chan1_ctrl.offset_trim      = {reg_val[3], reg_val[4][15:8]}; // R11
    chan1_ctrl.gain_trim        = {reg_val[5], reg_val[6][15:8]}; // R11
    chan2_ctrl.phase_delay      = reg_val[7][15:6];          // R1
    chan2_ctrl.dc_block_bypass  = reg_val[7][2];             // R2
    chan2_ctrl.dc_block_setting = reg_val[7][2] ? 4'h0
                                  : reg_val[0][3:0];         // R2 R9
    chan2_ctrl.input_select     = acr_input_sel_t'(reg_val[7][1:0]); // R3 R4
    chan2_ctrl.offset_trim      = 24'h00_0000;
    chan2_ctrl.gain_trim        = {`ACR_RST_GAIN_HI, 8'h00};
  end
  assign chan0_gain_trim_lower = reg_val[1][15:8];           // R8

  // Checks
  a_unmapped_zero_a: assert property (@(posedge clk) disable iff (rst)
    (st_q.state == ACR_ST_IDLE && avs_read && !(|reg_hit))
      |=> avs_readdata == 32'h0) // R10
    else $error("unmapped read not zero");
  cfg_rsvd_zero_a: assert property (@(posedge clk) disable iff (rst)
    reg_val[2][5:3] == 3'h0 && reg_val[7][5:3] == 3'h0) // R10
    else $error("config reserved bits set");
  trim_lo_rsvd_a: assert property (@(posedge clk) disable iff (rst)
    reg_val[4][7:0] == 8'h0 && reg_val[1][7:0] == 8'h0 &&
    reg_val[6][7:0] == 8'h0) // R6
    else $error("trim low reserved byte set");
  dc_rsvd_a: assert property (@(posedge clk) disable iff (rst)
    reg_val[0][15:4] == 12'h0) // R9
    else $error("dc block reserved bits set");
  phase_write_a: assert property (@(posedge clk) disable iff (rst)
    (wr_fire && reg_hit[2] && avs_byteenable[1:0] == 2'h3)
      |=> chan1_ctrl.phase_delay == $past(avs_writedata[15:6])) // R1
    else $error("phase delay not written");
  bypass_sel_a: assert property (@(posedge clk) disable iff (rst)
    chan1_ctrl.dc_block_bypass |-> chan1_ctrl.dc_block_setting == 4'h0) // R2
    else $error("bypass still uses global setting");
  ofs_concat_a: assert property (@(posedge clk) disable iff (rst)
    chan1_ctrl.offset_trim[7:0] == reg_val[4][15:8]) // R11
    else $error("offset trim concatenation wrong");
  gain_write_a: assert property (@(posedge clk) disable iff (rst)
    (wr_fire && reg_hit[5] && avs_byteenable[1:0] == 2'h3)
      |=> chan1_ctrl.gain_trim[23:8] == $past(avs_writedata[15:0])) // R7
    else $error("gain high not written");
  ofs_hi_write_a: assert property (@(posedge clk) disable iff (rst)
    (wr_fire && reg_hit[3] && avs_byteenable[1:0] == 2'h3)
      |=> chan1_ctrl.offset_trim[23:8] == $past(avs_writedata[15:0])) // R5
    else $error("offset high not written");
  mux_write_a: assert property (@(posedge clk) disable iff (rst)
    (wr_fire && reg_hit[2] && avs_byteenable[0])
      |=> chan1_ctrl.input_select == $past(avs_writedata[1:0])) // R3 R4
    else $error("input select not written");
  ans_time_a: assert property (@(posedge clk) disable iff (rst)
    (st_q.state == ACR_ST_IDLE && (avs_read || avs_write))
      |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("answer not in second cycle");
  c_read_c: cover property (@(posedge clk) avs_read && !avs_waitrequest);
  c_write_c: cover property (@(posedge clk) avs_write && !avs_waitrequest);
  c_bypass_c: cover property (@(posedge clk) chan1_ctrl.dc_block_bypass);
endmodule

/* File: verif/adc_channel_config_calibration_regs_bench.sv */
// Self-checking bench for the channel trim register bank
`timescale 1ns/1ps
module adc_channel_config_calibration_regs_bench;
  import acr_pkg::*;
  logic           clk = 1'b0;
  logic           rst = 1'b1;
  logic [7:0]     avs_address = 8'h00;
  logic           avs_read = 1'b0;
  logic           avs_write = 1'b0;
  logic [31:0]    avs_writedata = 32'h0000_0000;
  logic [3:0]     avs_byteenable = 4'hF;
  logic [31:0]    avs_readdata;
  logic           avs_waitrequest;
  acr_chan_ctrl_t chan1_ctrl;
  acr_chan_ctrl_t chan2_ctrl;
  logic [7:0]     chan0_gain_trim_lower;
  int             fails = 0;
  int             samples_checked = 0;
  int             cycles = 0;
  logic [31:0]    rd_q[$];
  logic [15:0]    hi, lo, cfg, g;
  logic [3:0]     dcb;
  // Every mapped word, then one unmapped place, with writable masks
  logic [7:0]     adr[9] = '{8'h20, 8'h34, 8'h38, 8'h3C, 8'h40,
                             8'h44, 8'h48, 8'h4C, 8'h50};
  logic [15:0]    rstv[9] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
                              16'h0000, 16'h8000, 16'h0000, 16'h0000,
                              16'h0000};
  logic [15:0]    msk[9] = '{16'h000F, 16'hFF00, 16'hFFC7, 16'hFFFF,
                             16'hFF00, 16'hFFFF, 16'hFF00, 16'hFFC7,
                             16'h0000};

  always #50 clk = ~clk;

  acr_regs acr_regs_inst (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .chan1_ctrl(chan1_ctrl), .chan2_ctrl(chan2_ctrl),
    .chan0_gain_trim_lower(chan0_gain_trim_lower));

  task automatic report_and_stop();
    if (fails == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] exp, input logic [31:0] got,
                     input string what);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Request held until waitrequest is seen low; next call may follow at once
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [15:0] d, input logic [3:0] be);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_byteenable <= be;
    avs_read <= ~w;
    avs_write <= w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d,
                    input logic [3:0] be);
    bus(1'b1, a, d, be);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    rd_q.push_back({16'h0000, exp});
    bus(1'b0, a, 16'h0000, 4'hF);
  endtask

  // Release the bus and let one edge pass so outputs have settled
  task automatic idle();
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  // Read results are judged at the edge that completes the access
  always @(posedge clk) begin
    if (!rst && avs_read && avs_waitrequest === 1'b0) begin
      cmp(rd_q.pop_front(), avs_readdata, "readdata");
    end
  end

  // Hang guard sized well above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles > 3000) begin
      fails++;
      report_and_stop();
    end
  end

  initial begin
    void'($urandom(98401));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    foreach (adr[i]) rd(adr[i], rstv[i]);
    // All ones everywhere: reserved bits and unmapped place stay zero
    foreach (adr[i]) wr(adr[i], 16'hFFFF, 4'hF);
    foreach (adr[i]) rd(adr[i], msk[i]);
    wr(8'h3A, 16'h0000, 4'hF);
    rd(8'h3A, 16'h0000);
    rd(8'h38, 16'hFFC7);
    idle();
    cmp(32'(chan1_ctrl.dc_block_setting), 32'h0, "bypassed setting");
    cmp(32'(chan0_gain_trim_lower), 32'hFF, "ch0 gain low");
    // Every input code, both bypass states, random phase on both channels
    for (int m = 0; m < 8; m++) begin
      cfg = {10'($urandom), 3'b000, 3'(m)};
      dcb = 4'($urandom);
      wr(8'h20, {12'hFFF, dcb}, 4'h3);
      wr(8'h38, cfg, 4'h3);
      wr(8'h4C, ~cfg, 4'h3);
      idle();
      cmp(32'(chan1_ctrl.phase_delay), 32'(cfg[15:6]), "phase");
      cmp(32'(chan1_ctrl.input_select), 32'(cfg[1:0]), "chan1_input_select");
      cmp(32'(chan2_ctrl.input_select), {30'h0, ~cfg[1:0]}, "chan2_input_select");
      cmp(32'(chan2_ctrl.phase_delay), {22'h0, ~cfg[15:6]}, "chan2_phase_delay");
      cmp(32'(chan2_ctrl.dc_block_bypass), {31'h0, ~cfg[2]}, "bypass2");
      cmp(32'(chan1_ctrl.dc_block_bypass), 32'(cfg[2]), "bypass");
      cmp(32'(chan1_ctrl.dc_block_setting), cfg[2] ? 32'h0 : 32'(dcb),
          "dc setting");
      cmp(32'(chan2_ctrl.dc_block_setting), cfg[2] ? 32'(dcb) : 32'h0,
          "dc setting 2");
    end
    // Random trims, high word above the low word's upper byte
    for (int k = 0; k < 6; k++) begin
      hi = 16'($urandom);
      lo = 16'($urandom);
      g = 16'($urandom);
      wr(8'h3C, hi, 4'h3);
      wr(8'h40, lo, 4'h3);
      wr(8'h44, g, 4'h3);
      wr(8'h44, ~g, 4'h2);
      wr(8'h48, ~lo, 4'h3);
      rd(8'h40, lo & 16'hFF00);
      rd(8'h44, {~g[15:8], g[7:0]});
      idle();
      cmp(32'(chan1_ctrl.offset_trim), {8'h00, hi, lo[15:8]}, "ofs");
      cmp(32'(chan1_ctrl.gain_trim), {8'h00, ~g[15:8], g[7:0], ~lo[15:8]},
          "gain");
    end
    // Second reset in mid-run restores defaults
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(8'h44, 16'h8000);
    rd(8'h38, 16'h0000);
    idle();
    report_and_stop();
  end
endmodule
